// ### design/tss_pkg.sv
// tss_pkg: constants and carrier types for the thermal shutdown sequencer.
// assumes a single 200 MHz clock and synchronous active-high reset.
package tss_pkg;
  localparam int unsigned CLK_FREQ_HZ      = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 5;
  // regulator-off delay after a level-two shutdown, in milliseconds
  localparam int unsigned RESTART_DELAY_MS = 1000;
  localparam int unsigned RESTART_DELAY_CYC =
    (RESTART_DELAY_MS * (CLK_FREQ_HZ / 1000));
  // dominant timeout (long variant only), in microseconds; plain default
  localparam int unsigned DOM_TIMEOUT_US   = 4000;
  localparam int unsigned DOM_TIMEOUT_CYC  =
    (DOM_TIMEOUT_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int unsigned CNT_W            = 32;

  // temperature comparator outputs; raw at the port, synchronized in tss_top
  typedef struct packed {
    logic level_two;     // above level-two threshold
    logic level_one;     // above level-one threshold
    logic level_one_rel; // above level-one release threshold
  } tss_temp_t;

  // enables and status toward the rest of the chip
  typedef struct packed {
    logic main_regulator_en;
    logic can_en;
    logic driver_en;
    logic wdog_restart;
  } tss_ctrl_t;

  typedef enum logic [1:0] {
    TSS_RUN,
    TSS_LVL1,
    TSS_LVL2_HOT,
    TSS_LVL2_WAIT
  } tss_state_t;
endpackage : tss_pkg

// ### design/tss_top.sv
// tss_top: two-level thermal protection sequencer with host reset gating
// and the long-variant transmit dominant timeout.
// assumes pin inputs are already synchronous to ref_clk; comparator outputs are synchronized here.
`timescale 1ns/1ps

// Contract
// - level one disables the high-side driver
// - level one keeps regulator and transceiver on
// - level two switches everything off
// - restart after below level one plus delay
// - driver back only below release threshold
// - only long dominant timeout is implemented
// - level-two shutdown restarts watchdog in timeout mode
// - host reset forces driver off, and fault only if the driver is requested outside level two
module tss_top
  import tss_pkg::*;
#(
  parameter int unsigned RESTART_CYC = RESTART_DELAY_CYC,
  parameter int unsigned DOM_CYC     = DOM_TIMEOUT_CYC
) (
  input  wire logic      ref_clk,
  input  wire logic      srst,
  input  wire tss_temp_t temp_raw,
  input  wire logic      driver_req,
  input  wire logic      can_req,
  input  wire logic      host_reset_n,
  input  wire logic      txd_in,
  output tss_ctrl_t      ctrl,
  output logic           driver_fault_n,
  output logic           tx_dominant,
  output logic           dominant_timeout
);

  tss_temp_t        sync1_q;
  tss_temp_t        temp_q;
  tss_state_t       state_q;
  tss_state_t       state_d;
  logic [CNT_W-1:0] dly_q;
  logic [CNT_W-1:0] dly_d;
  tss_ctrl_t        ctrl_q;
  tss_ctrl_t        ctrl_d;
  logic             fault_n_q;
  logic             fault_n_d;
  logic [CNT_W-1:0] dom_q;
  logic [CNT_W-1:0] dom_d;
  logic             tmo_q;
  logic             tmo_d;
  logic             txd_q;
  logic             txd_d;

  // two-stage synchronizer on the comparator outputs
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync1_q <= '0;
      temp_q  <= '0;
    end else begin
      sync1_q <= temp_raw;
      temp_q  <= sync1_q;
    end
  end

  // thermal state machine, level two checked first
  always_comb begin
    state_d = state_q;
    dly_d   = dly_q;
    case (state_q)
      TSS_RUN: begin
        if (temp_q.level_two) begin
          state_d = TSS_LVL2_HOT;
        end else if (temp_q.level_one) begin
          state_d = TSS_LVL1;
        end
      end
      TSS_LVL1: begin
        if (temp_q.level_two) begin
          state_d = TSS_LVL2_HOT;
        end else if (!temp_q.level_one_rel && !temp_q.level_one) begin
          state_d = TSS_RUN;
        end
      end
      TSS_LVL2_HOT: begin
        dly_d = '0;
        if (!temp_q.level_one && !temp_q.level_two) begin
          state_d = TSS_LVL2_WAIT;
        end
      end
      TSS_LVL2_WAIT: begin
        if (temp_q.level_one || temp_q.level_two) begin
          state_d = TSS_LVL2_HOT;
          dly_d   = '0;
        end else if (dly_q >= CNT_W'(RESTART_CYC - 1)) begin
          // driver stays off until below the release threshold
          state_d = TSS_LVL1;
          dly_d   = '0;
        end else begin
          dly_d = dly_q + CNT_W'(1);
        end
      end
      default: begin
        state_d = TSS_LVL2_HOT;
        dly_d   = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= TSS_RUN;
      dly_q   <= '0;
    end else begin
      state_q <= state_d;
      dly_q   <= dly_d;
    end
  end

  // output enables and driver diagnostic
  always_comb begin
    ctrl_d    = '0;
    fault_n_d = 1'b1;
    case (state_d)
      TSS_RUN: begin
        ctrl_d.main_regulator_en = 1'b1;
        ctrl_d.can_en            = can_req && host_reset_n;
        ctrl_d.driver_en         = driver_req && host_reset_n;
        fault_n_d = !(driver_req && !host_reset_n);
      end
      TSS_LVL1: begin
        ctrl_d.main_regulator_en = 1'b1;
        ctrl_d.can_en            = can_req && host_reset_n;
        ctrl_d.driver_en         = 1'b0;
        fault_n_d = !driver_req;
      end
      default: begin
        ctrl_d = '0;
      end
    endcase
    // one-cycle pulse when the level-two shutdown begins
    ctrl_d.wdog_restart = (state_d == TSS_LVL2_HOT) &&
                          (state_q != TSS_LVL2_HOT) &&
                          (state_q != TSS_LVL2_WAIT);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q    <= '0;
      fault_n_q <= 1'b1;
    end else begin
      ctrl_q    <= ctrl_d;
      fault_n_q <= fault_n_d;
    end
  end

  // long dominant timeout; released when the input returns recessive
  always_comb begin
    dom_d = dom_q;
    tmo_d = tmo_q;
    txd_d = 1'b0;
    if (!ctrl_d.can_en || txd_in) begin
      dom_d = '0;
      tmo_d = 1'b0;
    end else if (!tmo_q) begin
      // transmitter stays dominant for DOM_CYC cycles, then trips
      if (dom_q >= CNT_W'(DOM_CYC)) begin
        tmo_d = 1'b1;
      end else begin
        dom_d = dom_q + CNT_W'(1);
        txd_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dom_q <= '0;
      tmo_q <= 1'b0;
      txd_q <= 1'b0;
    end else begin
      dom_q <= dom_d;
      tmo_q <= tmo_d;
      txd_q <= txd_d;
    end
  end

  assign ctrl             = ctrl_q;
  assign driver_fault_n   = fault_n_q;
  assign tx_dominant      = txd_q;
  assign dominant_timeout = tmo_q;

endmodule : tss_top

// ### sim/tb_top.sv
// bench: directed scenarios on the sequencer
// assumes short restart and timeout counts
`timescale 1ns/1ps
module tb_top
  import tss_pkg::*;
;
  localparam int unsigned RC = 20;
  localparam int unsigned DC = 6;
  logic      ref_clk = 0, srst = 1, hold_rst = 0, dominant = 0;
  tss_temp_t temp = '0;
  tss_ctrl_t ctrl;
  logic      driver_req, can_req, host_reset_n, txd_in, flt_n, tx_d, d_to;
  int        miscompares = 0, tests_run = 0, n;
  // free-running clock
  always #2.5 ref_clk = !ref_clk;
  tss_mcu_model mcu (.hold_rst, .dominant, .driver_req, .can_req,
    .host_reset_n, .txd_in);
  tss_top #(.RESTART_CYC(RC), .DOM_CYC(DC)) dut (.ref_clk, .srst,
    .temp_raw(temp), .driver_req, .can_req, .host_reset_n, .txd_in, .ctrl,
    .driver_fault_n(flt_n), .tx_dominant(tx_d), .dominant_timeout(d_to));
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic t_lvl();
    temp = 3'h3;
    cyc(3);
    chk(ctrl, 4'hc);
    chk({1'b0, flt_n, tx_d, d_to}, 4'h0);
    temp = 3'h1;
    cyc(3);
    chk(ctrl, 4'hc);
    temp = 3'h0;
    cyc(3);
    chk(ctrl, 4'he);
    temp = 3'h7;
    cyc(3);
    chk(ctrl, 4'h1);
    temp = 3'h0;
    n = 0;
    while (ctrl.main_regulator_en !== 1'b1 && n < 99) begin
      cyc(1);
      n++;
    end
    chk({3'h0, n >= RC && n < 99}, 4'h1);
  endtask : t_lvl
  task automatic t_host();
    hold_rst = 1;
    cyc(1);
    chk(ctrl, 4'h8);
    chk({1'b0, flt_n, tx_d, d_to}, 4'h0);
    hold_rst = 0;
    dominant = 1;
    cyc(1);
    chk({1'b0, flt_n, tx_d, d_to}, 4'h6);
    cyc(DC);
    chk({1'b0, flt_n, tx_d, d_to}, 4'h5);
    dominant = 0;
    cyc(1);
    chk({1'b0, flt_n, tx_d, d_to}, 4'h4);
  endtask : t_host
  task automatic stop_test();
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  // main sequence, then a watchdog well past its length
  initial begin
    cyc(16);
    srst = 0;
    t_lvl();
    t_host();
    stop_test();
  end
  initial begin
    #5000;
    miscompares++;
    stop_test();
  end
endmodule : tb_top

// ### sim/tss_mcu_model.sv
// host model: pins the controller drives
// assumes bench commands change just after an edge
`timescale 1ns/1ps
module tss_mcu_model (
  input  wire logic hold_rst,
  input  wire logic dominant,
  output logic      driver_req,
  output logic      can_req,
  output logic      host_reset_n,
  output logic      txd_in
);
  // loads always wanted; reset and data follow the bench
  assign driver_req   = 1'b1;
  assign can_req      = 1'b1;
  assign host_reset_n = !hold_rst;
  assign txd_in       = !dominant; // low is dominant
endmodule : tss_mcu_model

// ### sim/tss_properties.sv
// checker: port-level properties of the sequencer
// assumes the bind hands on the short sim counts
`timescale 1ns/1ps
module tss_properties
  import tss_pkg::*;
#(parameter int unsigned RESTART_CYC = 20, DOM_CYC = 6) (
  input wire logic      ref_clk,
  input wire logic      srst,
  input wire tss_temp_t temp_raw,
  input wire logic      driver_req,
  input wire logic      host_reset_n,
  input wire tss_ctrl_t ctrl,
  input wire logic      driver_fault_n,
  input wire logic      tx_dominant,
  input wire logic      dominant_timeout
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [7:0] off_q; // cycles with the regulator off
  always_ff @(posedge ref_clk)
    off_q <= (srst || ctrl.main_regulator_en) ? '0 : off_q + 1'b1;
  a_lvl1_drv: assert property ($past(temp_raw.level_one, 3)
    |-> !ctrl.driver_en) else $error("driver on");
  a_lvl1_reg: assert property ((ctrl.main_regulator_en
    && !temp_raw.level_two) [*3] |=> ctrl.main_regulator_en)
    else $error("reg off");
  a_lvl2_off: assert property ($past(temp_raw.level_two, 3)
    |-> ctrl[3:1] == 3'h0) else $error("still on");
  a_restart_wait: assert property ($rose(ctrl.main_regulator_en)
    && off_q != 0 && !$past(srst, 2) |-> off_q >= RESTART_CYC)
    else $error("early restart");
  a_drv_release: assert property ($rose(ctrl.driver_en)
    |-> !$past(temp_raw.level_one_rel, 3)) else $error("early driver");
  a_dom_limit: assert property ($rose(dominant_timeout)
    |-> $past(tx_dominant, DOM_CYC) && !tx_dominant) else $error("dom");
  a_wdog_pulse: assert property ($rose(temp_raw.level_two)
    && ctrl.main_regulator_en |-> ##3 ctrl.wdog_restart
    ##1 !ctrl.wdog_restart) else $error("no restart");
  a_host_rst: assert property (!host_reset_n && driver_req
    |=> !ctrl.driver_en && !driver_fault_n) else $error("reset drv");
  c_lvl2: cover property (ctrl.wdog_restart);
  c_dom: cover property ($rose(dominant_timeout));
  c_fault: cover property (!driver_fault_n);
endmodule : tss_properties
bind tss_top tss_properties #(.RESTART_CYC(RESTART_CYC), .DOM_CYC(DOM_CYC))
  u_props (.*);
